// file: hw/mrm_core.sv
/*
  Mode register and internal resource mapping. Holds the operating mode
  configuration, the register/RAM/EEPROM position registers, and turns
  CPU accesses into registered chip selects, E clock and bus controls.
  Assumes a single-cycle CPU access strobe on core_clk_in, mode straps
  stable while rst_in is high, and registers reached at their offsets
  inside the relocatable register block.
*/
`timescale 1ns/100ps

// What this block does
// [R1] Mode select bits write once in normal; special ignores first write, no peripheral.
// [R2] Stretch enable clear: E toggles freely, never stretching.
// [R3] Stretch enable set: E high on external, low on hidden internal accesses.
// [R4] Stretch enable reads and acts as one in every expanded mode.
// [R5] Stretch enable: once in normal, anytime in special, readable in every mode but peripheral.
// [R6] Visibility set drives internal access activity outward; clear keeps it hidden.
// [R7] Special narrow with visibility shows internal data at full width.
// [R8] No visibility in any single-chip mode.
// [R9] Visibility bit: once in normal, special ignores only the first write.
// [R10] External bus stops in wait after a delay when enabled; special never writes it.
// [R11] Single-chip keeps expansion port registers mapped always.
// [R12] Port emulation removes port registers in expanded or peripheral mode.
// [R13] Position fields are write-once in normal modes.
// [R14] Mapping writes act from the second cycle after the write.
// [R15] Overlaps resolve: debug, registers, RAM, EEPROM, flash, external.
// [R16] Flash: fixed array low and high plus a paged window.
// [R17] 1K register block at zero after reset, movable to any 2K boundary.
// [R18] Five-bit register position field gives address bits 15 to 11.
// [R19] Mapping interface stops in wait when enabled; special never writes it.
// [R20] Word access across the RAM array split takes two bus cycles.
// [R21] RAM defaults to base 2000, movable to any 8K boundary.
// [R22] RAM position holds address bits 15 to 13, write-once in normal.
// [R23] Selects come from position compares, then precedence, then the outputs.
module mrm_core
  import mrm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Mode straps, sampled while reset is held
  input wire logic strap_special_n_in,
  input wire logic strap_mode_hi_in,
  input wire logic strap_mode_lo_in,
  // CPU access
  input wire logic cpu_valid_in,
  input wire logic cpu_write_in,
  input wire logic cpu_word_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic [7:0] cpu_wdata_in,
  // System state
  input wire logic dbg_active_in,
  input wire logic wait_mode_in,
  // Register read data
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Chip selects
  output logic [MRM_SEL_W-1:0] sel_out,
  output logic ram_two_cycle_out,
  // External bus control
  output logic e_clk_out,
  output logic vis_drive_out,
  output logic vis_wide_out,
  output logic ext_bus_off_out,
  output logic map_iface_off_out,
  output logic port_regs_mapped_out,
  output logic [2:0] mode_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [2:0] mode_q;
  logic clock_stretch_enable_q;
  logic internal_visibility_q;
  logic ext_bus_wait_stop_q;
  logic emk_q;
  logic eme_q;
  logic mode_wr_seen_q;
  logic [4:0] reg_pos_q;
  logic map_iface_wait_stop_q;
  logic regpos_wr_seen_q;
  logic [2:0] ram_pos_q;
  logic rampos_wr_seen_q;
  logic [3:0] ee_pos_q;
  logic ee_on_q;
  logic eepos_wr_seen_q;
  logic [4:0] reg_pos_act_q;
  logic [2:0] ram_pos_act_q;
  logic [3:0] ee_pos_act_q;
  logic ee_on_act_q;
  logic [3:0] wait_cnt_q;
  logic e_phase_q;

  logic special;
  logic single;
  logic expanded;
  logic clock_stretch_enable_eff;
  logic ee_on_eff;
  logic port_unmapped;
  logic reg_hit;
  logic [9:0] reg_ofs;
  logic wr_mode;
  logic wr_regpos;
  logic wr_rampos;
  logic wr_eepos;
  logic [2:0] mode_req;
  logic [MRM_SEL_W-1:0] sel_d;
  logic [7:0] rdata_d;

  // ---------------------------------------------------------------
  // Mode-derived conditions
  // ---------------------------------------------------------------
  assign special = mrm_special(mode_q);
  assign single = mrm_single_chip(mode_q);
  assign expanded = mrm_expanded(mode_q);
  assign clock_stretch_enable_eff = clock_stretch_enable_q || expanded; // [R4]
  assign ee_on_eff = ee_on_act_q || single;
  assign port_unmapped = emk_q && !single; // [R11] [R12]

  // Register block hit uses the active base so relocation lags like the map
  assign reg_ofs = cpu_addr_in[9:0];
  assign reg_hit = cpu_valid_in && (sel_d[MRM_SEL_REG]);
  // Mode register is not in the map in peripheral mode
  assign wr_mode = reg_hit && cpu_write_in && (reg_ofs == MRM_OFS_MODE) && (mode_q != MRM_MODE_SPER);
  assign wr_regpos = reg_hit && cpu_write_in && (reg_ofs == MRM_OFS_REGPOS);
  assign wr_rampos = reg_hit && cpu_write_in && (reg_ofs == MRM_OFS_RAMPOS);
  assign wr_eepos = reg_hit && cpu_write_in && (reg_ofs == MRM_OFS_EEPOS);
  assign mode_req = {cpu_wdata_in[MRM_B_SPECIAL_MODE_FLAG_N], cpu_wdata_in[MRM_B_MODE_SELECT_HI], cpu_wdata_in[MRM_B_MODE_SELECT_LO]};

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  mrm_decode u_decode (
    .addr_in(cpu_addr_in),
    .reg_pos_in(reg_pos_act_q),
    .ram_pos_in(ram_pos_act_q),
    .ee_pos_in(ee_pos_act_q),
    .ee_on_in(ee_on_eff),
    .dbg_active_in(dbg_active_in),
    .port_unmapped_in(port_unmapped),
    .sel_out(sel_d)
  );

  // ---------------------------------------------------------------
  // Operating mode register
  // ---------------------------------------------------------------
  // Straps are loaded while reset is held; reserved code is forced to peripheral
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mode_q <= (({strap_special_n_in, strap_mode_hi_in, strap_mode_lo_in} == MRM_MODE_RSV) ?
                 MRM_MODE_SPER : {strap_special_n_in, strap_mode_hi_in, strap_mode_lo_in});
      clock_stretch_enable_q <= 1'b1;
      internal_visibility_q <= !strap_special_n_in;
      ext_bus_wait_stop_q <= 1'b0;
      emk_q <= !strap_special_n_in;
      eme_q <= !strap_special_n_in;
      mode_wr_seen_q <= 1'b0;
    end else if (wr_mode) begin
      mode_wr_seen_q <= 1'b1;
      // Normal: one write only; special: every write but the first [R1]
      if ((special && mode_wr_seen_q) || (!special && !mode_wr_seen_q)) begin
        if (mode_req != MRM_MODE_SPER && mode_req != MRM_MODE_RSV && (special || mode_req[2])) begin
          mode_q <= mode_req; // [R1]
        end
      end
      if (special || !mode_wr_seen_q) begin
        clock_stretch_enable_q <= cpu_wdata_in[MRM_B_CLOCK_STRETCH_ENABLE]; // [R5]
      end
      if ((special && mode_wr_seen_q) || (!special && !mode_wr_seen_q)) begin
        internal_visibility_q <= cpu_wdata_in[MRM_B_INTERNAL_VISIBILITY]; // [R9]
        emk_q <= cpu_wdata_in[MRM_B_EMK]; // [R12]
        eme_q <= cpu_wdata_in[MRM_B_EME];
      end
      if (!special) begin
        ext_bus_wait_stop_q <= cpu_wdata_in[MRM_B_EXT_BUS_WAIT_STOP]; // [R10]
      end
    end
  end

  // ---------------------------------------------------------------
  // Position registers; position fields write-once in normal modes
  // ---------------------------------------------------------------
  // Software should write these at init even with defaults to lock them
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_pos_q <= MRM_REGPOS_RST;
      map_iface_wait_stop_q <= 1'b0;
      regpos_wr_seen_q <= 1'b0;
    end else if (wr_regpos) begin
      regpos_wr_seen_q <= 1'b1;
      if (special || !regpos_wr_seen_q) begin
        reg_pos_q <= cpu_wdata_in[7:3]; // [R13] [R18]
      end
      if (!special) begin
        map_iface_wait_stop_q <= cpu_wdata_in[MRM_B_MAP_IFACE_WAIT_STOP]; // [R19]
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ram_pos_q <= MRM_RAMPOS_RST; // [R21]
      rampos_wr_seen_q <= 1'b0;
    end else if (wr_rampos) begin
      rampos_wr_seen_q <= 1'b1;
      if (special || !rampos_wr_seen_q) begin
        ram_pos_q <= cpu_wdata_in[7:5]; // [R13] [R22]
      end
    end
  end

  // Enable bit of the EEPROM position register is free to write
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ee_pos_q <= MRM_EEPOS_RST;
      ee_on_q <= MRM_EEON_RST;
      eepos_wr_seen_q <= 1'b0;
    end else if (wr_eepos) begin
      eepos_wr_seen_q <= 1'b1;
      ee_on_q <= cpu_wdata_in[MRM_B_EEON];
      if (special || !eepos_wr_seen_q) begin
        ee_pos_q <= cpu_wdata_in[7:4]; // [R13]
      end
    end
  end

  // ---------------------------------------------------------------
  // Active map copies: one extra stage so a write steers decode from the
  // second cycle after it, never mid-instruction of the write itself
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_pos_act_q <= MRM_REGPOS_RST; // [R17]
      ram_pos_act_q <= MRM_RAMPOS_RST;
      ee_pos_act_q <= MRM_EEPOS_RST;
      ee_on_act_q <= MRM_EEON_RST;
    end else begin
      reg_pos_act_q <= reg_pos_q; // [R14]
      ram_pos_act_q <= ram_pos_q; // [R14]
      ee_pos_act_q <= ee_pos_q; // [R14]
      ee_on_act_q <= ee_on_q;
    end
  end

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    case (reg_ofs)
      MRM_OFS_MODE: begin
        if (mode_q != MRM_MODE_SPER) begin
          rdata_d = {mode_q, clock_stretch_enable_eff, internal_visibility_q, ext_bus_wait_stop_q, emk_q, eme_q}; // [R4] [R5] [R9]
        end
      end
      MRM_OFS_REGPOS: begin
        rdata_d = {reg_pos_q, 2'b00, map_iface_wait_stop_q}; // [R18]
      end
      MRM_OFS_RAMPOS: begin
        rdata_d = {ram_pos_q, 5'h00}; // [R22]
      end
      MRM_OFS_EEPOS: begin
        rdata_d = {ee_pos_q, 3'h0, ee_on_q || single};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_hit && !cpu_write_in;
      reg_rdata_out <= (reg_hit && !cpu_write_in) ? rdata_d : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Chip selects and RAM split detect
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sel_out <= '0;
      ram_two_cycle_out <= 1'b0;
    end else begin
      sel_out <= cpu_valid_in ? sel_d : '0; // [R23]
      // Word starting on the last byte of the lower 4K array spans both arrays
      ram_two_cycle_out <= cpu_valid_in && cpu_word_in && sel_d[MRM_SEL_RAM] &&
                           (cpu_addr_in[12:0] == {1'b0, MRM_RAM_SPLIT_OFS}); // [R20]
    end
  end

  // ---------------------------------------------------------------
  // E clock
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      e_phase_q <= 1'b0;
      e_clk_out <= 1'b0;
    end else begin
      e_phase_q <= !e_phase_q;
      if (!clock_stretch_enable_eff) begin
        e_clk_out <= !e_phase_q; // [R2]
      end else if (cpu_valid_in && sel_d[MRM_SEL_EXT]) begin
        e_clk_out <= 1'b1; // [R3]
      end else if (cpu_valid_in && !(internal_visibility_q && !single)) begin
        e_clk_out <= 1'b0; // [R3]
      end else begin
        e_clk_out <= !e_phase_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Visibility, wait shutdown and mode status
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      vis_drive_out <= 1'b0;
      vis_wide_out <= 1'b0;
      port_regs_mapped_out <= 1'b1;
      mode_out <= 3'h0;
    end else begin
      // Single-chip modes have no bus to show anything on
      vis_drive_out <= cpu_valid_in && !sel_d[MRM_SEL_EXT] && internal_visibility_q && !single; // [R6] [R8]
      vis_wide_out <= cpu_valid_in && !sel_d[MRM_SEL_EXT] && internal_visibility_q && (mode_q == MRM_MODE_SEN); // [R7]
      port_regs_mapped_out <= !port_unmapped; // [R11] [R12]
      mode_out <= mode_q;
    end
  end

  // Delay lets the last external cycle finish before the bus is gated
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wait_cnt_q <= 4'h0;
      ext_bus_off_out <= 1'b0;
      map_iface_off_out <= 1'b0;
    end else begin
      if (wait_mode_in && ext_bus_wait_stop_q) begin
        if (wait_cnt_q != MRM_EXT_WAIT_DELAY) begin
          wait_cnt_q <= wait_cnt_q + 4'h1;
        end
      end else begin
        wait_cnt_q <= 4'h0;
      end
      ext_bus_off_out <= wait_mode_in && ext_bus_wait_stop_q && (wait_cnt_q == MRM_EXT_WAIT_DELAY); // [R10]
      map_iface_off_out <= wait_mode_in && map_iface_wait_stop_q; // [R19]
    end
  end

endmodule

// file: hw/mrm_decode.sv
/*
  Address decoder of the mode and resource mapping block: compares the
  upper CPU address bits with each position field and resolves overlaps
  by fixed precedence into a one-hot select vector.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
module mrm_decode
  import mrm_pkg::*;
(
  // Access
  input wire logic [15:0] addr_in,
  // Map state
  input wire logic [4:0] reg_pos_in,
  input wire logic [2:0] ram_pos_in,
  input wire logic [3:0] ee_pos_in,
  input wire logic ee_on_in,
  input wire logic dbg_active_in,
  input wire logic port_unmapped_in,
  // Result
  output logic [MRM_SEL_W-1:0] sel_out
);

  logic hit_dbg;
  logic hit_reg;
  logic hit_ram;
  logic hit_ee;
  logic hit_flash;

  // ---------------------------------------------------------------
  // Raw hits per resource
  // ---------------------------------------------------------------
  always_comb begin
    hit_dbg = dbg_active_in && ((addr_in >= MRM_DBG_ROM_LO) ||
              ((addr_in >= MRM_DBG_LO) && (addr_in <= MRM_DBG_REG_HI)));
    // First 1K of the selected 2K block; emulated port regs fall outside [R17] [R23]
    hit_reg = (addr_in[15:11] == reg_pos_in) && !addr_in[10] &&
              !(port_unmapped_in && ((addr_in[9:0] == MRM_OFS_PORT_DATA) ||
                                     (addr_in[9:0] == MRM_OFS_PORT_DIR)));
    hit_ram = (addr_in[15:13] == ram_pos_in); // [R21] [R23]
    // EEPROM sits in the upper 2K of its 4K block
    hit_ee = ee_on_in && (addr_in[15:12] == ee_pos_in) && addr_in[11]; // [R23]
    // Fixed array low and high, plus the paged window between them [R16]
    hit_flash = (addr_in[15:14] == MRM_FLASH_FIX_LO) || (addr_in[15:14] == MRM_FLASH_WINDOW) ||
                (addr_in[15:14] == MRM_FLASH_FIX_HI);
  end

  // ---------------------------------------------------------------
  // Precedence: debug, registers, RAM, EEPROM, flash, external
  // ---------------------------------------------------------------
  always_comb begin
    sel_out = '0;
    if (hit_dbg) begin
      sel_out[MRM_SEL_DBG] = 1'b1; // [R15]
    end else if (hit_reg) begin
      sel_out[MRM_SEL_REG] = 1'b1; // [R15]
    end else if (hit_ram) begin
      sel_out[MRM_SEL_RAM] = 1'b1; // [R15]
    end else if (hit_ee) begin
      sel_out[MRM_SEL_EE] = 1'b1; // [R15]
    end else if (hit_flash) begin
      sel_out[MRM_SEL_FLASH] = 1'b1; // [R15]
    end else begin
      sel_out[MRM_SEL_EXT] = 1'b1; // [R15]
    end
  end

endmodule

// file: hw/mrm_pkg.sv
/*
  Package for the mode and resource mapping block: register offsets inside
  the register block, field positions, reset values, mode codes, the fixed
  address ranges and the mode decode helpers shared by the main module and the checker.
  Assumes a 16-bit CPU address and an 8-bit register data path.
*/
package mrm_pkg;

  // ---------------------------------------------------------------
  // Register offsets within the 1K register block
  // ---------------------------------------------------------------
  localparam logic [9:0] MRM_OFS_MODE = 10'h00B;
  localparam logic [9:0] MRM_OFS_RAMPOS = 10'h010;
  localparam logic [9:0] MRM_OFS_REGPOS = 10'h011;
  localparam logic [9:0] MRM_OFS_EEPOS = 10'h012;
  localparam logic [9:0] MRM_OFS_PORT_DATA = 10'h0FC;
  localparam logic [9:0] MRM_OFS_PORT_DIR = 10'h0FD;

  // ---------------------------------------------------------------
  // Operating mode register bit positions
  // ---------------------------------------------------------------
  localparam int MRM_B_SPECIAL_MODE_FLAG_N = 7;
  localparam int MRM_B_MODE_SELECT_HI = 6;
  localparam int MRM_B_MODE_SELECT_LO = 5;
  localparam int MRM_B_CLOCK_STRETCH_ENABLE = 4;
  localparam int MRM_B_INTERNAL_VISIBILITY = 3;
  localparam int MRM_B_EXT_BUS_WAIT_STOP = 2;
  localparam int MRM_B_EMK = 1;
  localparam int MRM_B_EME = 0;

  // Position register fields
  localparam int MRM_B_MAP_IFACE_WAIT_STOP = 0;
  localparam int MRM_B_EEON = 0;

  // ---------------------------------------------------------------
  // Mode codes {special_mode_flag_n, mode_select_hi, mode_select_lo}
  // ---------------------------------------------------------------
  localparam logic [2:0] MRM_MODE_SSC = 3'h0;
  localparam logic [2:0] MRM_MODE_SEN = 3'h1;
  localparam logic [2:0] MRM_MODE_SPER = 3'h2;
  localparam logic [2:0] MRM_MODE_SEW = 3'h3;
  localparam logic [2:0] MRM_MODE_NSC = 3'h4;
  localparam logic [2:0] MRM_MODE_NEN = 3'h5;
  localparam logic [2:0] MRM_MODE_RSV = 3'h6;
  localparam logic [2:0] MRM_MODE_NEW = 3'h7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] MRM_REGPOS_RST = 5'h00;
  localparam logic [2:0] MRM_RAMPOS_RST = 3'h1;
  localparam logic [3:0] MRM_EEPOS_RST = 4'h0;
  localparam logic MRM_EEON_RST = 1'b1;

  // ---------------------------------------------------------------
  // Fixed ranges and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] MRM_DBG_LO = 16'hFF00;
  localparam logic [15:0] MRM_DBG_REG_HI = 16'hFF06;
  localparam logic [15:0] MRM_DBG_ROM_LO = 16'hFF20;
  localparam logic [1:0] MRM_FLASH_FIX_LO = 2'h1;
  localparam logic [1:0] MRM_FLASH_WINDOW = 2'h2;
  localparam logic [1:0] MRM_FLASH_FIX_HI = 2'h3;
  localparam logic [11:0] MRM_RAM_SPLIT_OFS = 12'hFFF;
  localparam logic [3:0] MRM_EXT_WAIT_DELAY = 4'h4;

  // Select vector bit positions
  localparam int MRM_SEL_DBG = 0;
  localparam int MRM_SEL_REG = 1;
  localparam int MRM_SEL_RAM = 2;
  localparam int MRM_SEL_EE = 3;
  localparam int MRM_SEL_FLASH = 4;
  localparam int MRM_SEL_EXT = 5;
  localparam int MRM_SEL_W = 6;

  // ---------------------------------------------------------------
  // Mode decode helpers
  // ---------------------------------------------------------------
  function automatic logic mrm_single_chip(input logic [2:0] mode);
    return (mode[1:0] == 2'b00);
  endfunction

  function automatic logic mrm_special(input logic [2:0] mode);
    return ~mode[2];
  endfunction

  function automatic logic mrm_expanded(input logic [2:0] mode);
    return (mode == MRM_MODE_SEN) || (mode == MRM_MODE_SEW) ||
           (mode == MRM_MODE_NEN) || (mode == MRM_MODE_NEW);
  endfunction

endpackage

// file: tb/mrm_assertions.sv
/*
  Port checker for mrm_core: selects, register answers, visibility, E clock
  and wait shutdown. Assumes one clock domain and the synchronous reset.
*/
`timescale 1ns/100ps
module mrm_assertions
  import mrm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Stimulus side
  input wire logic cpu_valid_in,
  input wire logic cpu_write_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic dbg_active_in,
  input wire logic wait_mode_in,
  // Design outputs
  input wire logic reg_rvalid_out,
  input wire logic [MRM_SEL_W-1:0] sel_out,
  input wire logic e_clk_out,
  input wire logic vis_drive_out,
  input wire logic vis_wide_out,
  input wire logic ext_bus_off_out,
  input wire logic map_iface_off_out,
  input wire logic port_regs_mapped_out,
  input wire logic [2:0] mode_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  // Wait just entered: too early for the bus to be off yet
  sequence wait_entry;
    !wait_mode_in ##1 wait_mode_in [*4];
  endsequence

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sel_onehot_a: assert property (cpu_valid_in && !wait_mode_in |=> $onehot(sel_out))
    else $error("select not one-hot after access");
  sel_idle_a: assert property (!cpu_valid_in |=> sel_out == '0)
    else $error("select without access");
  debug_first_a: assert property (cpu_valid_in && dbg_active_in && cpu_addr_in >= MRM_DBG_ROM_LO
    |=> sel_out[MRM_SEL_DBG]) else $error("debug rom lost precedence");
  rvalid_cause_a: assert property (reg_rvalid_out |-> $past(cpu_valid_in) && !$past(cpu_write_in)
    && sel_out[MRM_SEL_REG]) else $error("read answer without register read");
  vis_single_a: assert property (mrm_single_chip(mode_out) |-> !vis_drive_out)
    else $error("visibility in single chip");
  vis_wide_a: assert property (vis_wide_out |-> vis_drive_out && mode_out == MRM_MODE_SEN)
    else $error("wide visibility outside special narrow");
  port_single_a: assert property (mrm_single_chip(mode_out) |-> port_regs_mapped_out)
    else $error("port registers unmapped in single chip");
  e_ext_high_a: assert property (sel_out[MRM_SEL_EXT] && mrm_expanded(mode_out) |-> e_clk_out)
    else $error("E low on external cycle");
  ext_early_a: assert property (wait_entry |-> !ext_bus_off_out)
    else $error("external bus off before delay");
  map_off_a: assert property (map_iface_off_out |-> $past(wait_mode_in))
    else $error("mapping interface off outside wait");
endmodule

bind mrm_core mrm_assertions u_chk (.core_clk_in, .rst_in, .cpu_valid_in, .cpu_write_in, .cpu_addr_in,
  .dbg_active_in, .wait_mode_in, .reg_rvalid_out, .sel_out, .e_clk_out, .vis_drive_out, .vis_wide_out,
  .ext_bus_off_out, .map_iface_off_out, .port_regs_mapped_out, .mode_out);

// file: tb/mrm_core_tb.sv
/*
  Testbench for mrm_core: register reads and writes, decode and mode runs.
  Assumes the offsets and select positions of mrm_pkg.
*/
`timescale 1ns/100ps
module mrm_core_tb
  import mrm_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 0, rst = 1, s_n = 1, s_hi = 0, s_lo = 0, valid = 0, wr_en = 0, word = 0, dbg = 0, wt = 0;
  logic [15:0] addr = 16'h0000, rb = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, ext_cnt;
  logic rvalid, two, eclk, vis, wide, ebo, mio, prm;
  logic [5:0] sel;
  logic [2:0] mode;
  int n_errors = 0, checks = 0;

  always #10 clk = ~clk;

  mrm_core u_dut (.core_clk_in(clk), .rst_in(rst), .strap_special_n_in(s_n), .strap_mode_hi_in(s_hi),
    .strap_mode_lo_in(s_lo), .cpu_valid_in(valid), .cpu_write_in(wr_en), .cpu_word_in(word),
    .cpu_addr_in(addr), .cpu_wdata_in(wdata), .dbg_active_in(dbg), .wait_mode_in(wt),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .sel_out(sel), .ram_two_cycle_out(two),
    .e_clk_out(eclk), .vis_drive_out(vis), .vis_wide_out(wide), .ext_bus_off_out(ebo),
    .map_iface_off_out(mio), .port_regs_mapped_out(prm), .mode_out(mode));
  mrm_ext_bus_model u_ext (.core_clk_in(clk), .rst_in(rst), .sel_ext_in(sel[MRM_SEL_EXT]), .e_clk_in(eclk),
    .ext_count_out(ext_cnt));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access, held for a single taking edge; outputs settle before return
  task automatic acc(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    valid = 1;
    wr_en = w;
    word = wd;
    addr = a;
    wdata = d;
    @(negedge clk);
    valid = 0;
  endtask
  task automatic rd(input logic [15:0] ofs, input logic [7:0] exp);
    acc(0, 0, rb + ofs, 8'h00);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task automatic wr(input logic [15:0] ofs, input logic [7:0] d);
    acc(1, 0, rb + ofs, d);
  endtask
  task automatic sl(input logic [15:0] a, input logic [7:0] exp);
    acc(0, 0, a, 8'h00);
    chk({2'h0, sel}, exp);
  endtask
  task automatic boot(input logic n, input logic h, input logic l);
    {s_n, s_hi, s_lo} = {n, h, l};
    rst = 1;
    rb = 16'h0000;
    repeat (6) @(negedge clk);
    rst = 0;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    boot(1, 0, 0);
    rd(16'h000B, 8'h90);
    rd(16'h0010, 8'h20);
    rd(16'h0011, 8'h00);
    sl(16'h2000, 8'h04);
    sl(16'h0000, 8'h02);
    sl(16'h0800, 8'h08);
    sl(16'h4000, 8'h10);
    dbg = 1;
    sl(16'hFF20, 8'h01);
    sl(16'hFF10, 8'h10);
    dbg = 0;
    wr(16'h000B, 8'h8C);
    rd(16'h000B, 8'h8C);
    wr(16'h000B, 8'h90);
    rd(16'h000B, 8'h88);
    acc(0, 0, 16'h2000, 8'h00);
    chk({7'h00, vis}, 8'h00);
    chk({7'h00, prm}, 8'h01);
    wr(16'h0010, 8'h00);
    sl(16'h0900, 8'h04);
    sl(16'h0010, 8'h02);
    wr(16'h0010, 8'hE0);
    rd(16'h0010, 8'h00);
    wr(16'h0011, 8'h09);
    rb = 16'h0800;
    rd(16'h0011, 8'h09);
    sl(16'h0000, 8'h04);
    wr(16'h000B, 8'h94);
    rd(16'h000B, 8'h8C);
    wt = 1;
    repeat (8) @(negedge clk);
    chk({7'h00, ebo}, 8'h01);
    chk({7'h00, mio}, 8'h01);
    wt = 0;
    // Line the hidden access up with E high, so a stretch to low would show
    if (!eclk) @(negedge clk);
    acc(0, 0, 16'h0000, 8'h00);
    chk({7'h00, eclk}, 8'h01);
    boot(0, 1, 1);
    rd(16'h000B, 8'h7B);
    wr(16'h000B, 8'h2B);
    rd(16'h000B, 8'h7B);
    wr(16'h000B, 8'h3F);
    rd(16'h000B, 8'h3B);
    wr(16'h000B, 8'h5B);
    rd(16'h000B, 8'h3B);
    acc(0, 0, 16'h2000, 8'h00);
    chk({7'h00, vis}, 8'h01);
    chk({7'h00, wide}, 8'h01);
    chk({7'h00, prm}, 8'h00);
    acc(0, 1, 16'h2FFF, 8'h00);
    chk({7'h00, two}, 8'h01);
    wr(16'h000B, 8'h33);
    rd(16'h000B, 8'h33);
    // Aligned to E high: a free-running E would still read high here
    if (!eclk) @(negedge clk);
    acc(0, 0, 16'h2000, 8'h00);
    chk({7'h00, eclk}, 8'h00);
    chk({7'h00, vis}, 8'h00);
    sl(16'h1000, 8'h20);
    @(negedge clk);
    chk(ext_cnt, 8'h01);
    end_sim;
  end

  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    n_errors++;
    end_sim;
  end
endmodule

// file: tb/mrm_ext_bus_model.sv
/*
  External bus partner: counts external cycles that the E clock marks.
  Assumes the select and E clock come straight from mrm_core.
*/
`timescale 1ns/100ps
module mrm_ext_bus_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Bus view
  input wire logic sel_ext_in,
  input wire logic e_clk_in,
  // Result
  output logic [7:0] ext_count_out
);
  // A cycle with E low is not latched by external memory, so it is not counted
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ext_count_out <= 8'h00;
    end else if (sel_ext_in && e_clk_in) begin
      ext_count_out <= ext_count_out + 8'h01;
    end
  end
endmodule
